// file: core/rwa_ctrl.v
// Purpose: host controller that computes main window start address and line
//    offset for a chosen rotation and writes them into the display device
// Assumes: software orders over classic Wishbone; device takes register writes
//    by a four-phase request/acknowledge on its pins
// Notes: bpp is given as its base-2 logarithm (0..4 for 1..16 bpp)
//
// Function
// RULE1: each intermediate result is an integer; divisions truncate via right shifts
// RULE2: upper-left byte address is upper times stride plus left divided by bpp
// RULE3: rotation 0 start is upper-left address over 4; stride is width*bpp/8
// RULE4: rotation 0 line offset is display width over (32/bpp)
// RULE5: rotation 90 start is ((ula + B + ((4-B)&3))/4)-1, B=height*bpp/8
// RULE6: rotations 90 and 270 line offset is panel height over (32/bpp)
// RULE7: rotation 180 start adds stride*(height-1), W and pad, quartered minus one
// RULE8: rotation 180 line offset uses panel width, as the worked example does
// RULE9: rotation 270 stride is height*bpp/8; start is (ula+(width-1)*stride)/4
// RULE10: placing the image at buffer address zero is left to software origin
// RULE11: rotation lives in bits 17:16 of the device settings register
// RULE12: device reads start as a dword address, zero at buffer start
// RULE13: device fetches from start and steps by line offset per line
// RULE14: device holds written values until rewritten; reads return them
`include "rwa_consts.vh"

module rwa_ctrl #(
   parameter DIM_W = 16
) (
   input wire CLK,
   input wire ARST_N,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   output reg [7:0] DEV_ADDR,
   output reg [31:0] DEV_WDATA,
   output reg DEV_WR,
   input wire DEV_ACK
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg rst_q1;
   reg rst_n;

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // ----------------------------------------------------------------
   // state and storage
   // ----------------------------------------------------------------
   localparam ST_IDLE = 4'h0;
   localparam ST_MUL_UL = 4'h1;
   localparam ST_WAIT_UL = 4'h2;
   localparam ST_MUL_SPAN = 4'h3;
   localparam ST_WAIT_SPAN = 4'h4;
   localparam ST_CALC = 4'h5;
   localparam ST_WR_REQ = 4'h6;
   localparam ST_WR_REL = 4'h7;
   localparam ST_FINISH = 4'h8;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [1:0] wr_idx;
   reg [31:0] settings;
   reg [2:0] pixfmt;
   reg [31:0] panel;
   reg [31:0] origin;
   reg [31:0] start_res;
   reg [31:0] offset_res;
   reg [31:0] ula_prod;
   reg done_flag;
   reg [1:0] rot;
   reg [2:0] lg;

   wire ack_sync;
   wire mul_done;
   wire [2*DIM_W-1:0] mul_prod;
   reg mul_start;
   reg [DIM_W-1:0] mul_a;
   reg [DIM_W-1:0] mul_b;

   wire busy = (state != ST_IDLE);
   wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire wb_wr = wb_req && WB_WE_I;
   wire go = wb_wr && (WB_ADR_I == `RWA_OFS_CTRL) && WB_SEL_I[0] && WB_DAT_I[`RWA_CTRL_GO];
   wire done_clr = wb_wr && (WB_ADR_I == `RWA_OFS_STATUS) && WB_SEL_I[0]
                   && WB_DAT_I[`RWA_STAT_DONE];

   // ----------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------
   wire [DIM_W-1:0] p_width = panel[DIM_W-1:0];
   wire [DIM_W-1:0] p_height = panel[16+DIM_W-1:16];
   wire [DIM_W-1:0] o_left = origin[DIM_W-1:0];
   wire [DIM_W-1:0] o_upper = origin[16+DIM_W-1:16];
   wire [31:0] width32 = {{(32-DIM_W){1'b0}}, p_width};
   wire [31:0] height32 = {{(32-DIM_W){1'b0}}, p_height};
   // bytes per unrotated line, width- or height-based
   wire [31:0] bytes_w = (width32 << lg) >> `RWA_BYTE_SHIFT; // [RULE3] [RULE1]
   wire [31:0] bytes_h = (height32 << lg) >> `RWA_BYTE_SHIFT; // [RULE9] [RULE1]
   wire [31:0] stride = (rot == `RWA_ROT_270) ? bytes_h : bytes_w; // [RULE9]
   wire [31:0] left_bytes = {{(32-DIM_W){1'b0}}, o_left} >> lg; // [RULE1]
   wire [31:0] ula = ula_prod + left_bytes; // [RULE2]
   wire [31:0] span = mul_prod[31:0];
   wire [1:0] pad_h = 2'h0 - bytes_h[1:0]; // [RULE5]
   wire [1:0] pad_w = 2'h0 - bytes_w[1:0]; // [RULE7]
   wire [31:0] sum90 = ula + bytes_h + {30'h0, pad_h};
   wire [31:0] sum180 = ula + span + bytes_w + {30'h0, pad_w};
   wire [31:0] sum270 = ula + span;
   wire [2:0] ofs_shift = `RWA_DWORD_BITS_LOG2 - lg;

   reg [31:0] next_start;
   reg [31:0] next_offset;

   always @* begin
      case (rot)
         `RWA_ROT_0: begin
            next_start = ula >> `RWA_DWORD_SHIFT; // [RULE3] [RULE12]
            next_offset = width32 >> ofs_shift; // [RULE4]
         end
         `RWA_ROT_90: begin
            next_start = (sum90 >> `RWA_DWORD_SHIFT) - 32'h1; // [RULE5] [RULE1]
            next_offset = height32 >> ofs_shift; // [RULE6]
         end
         `RWA_ROT_180: begin
            next_start = (sum180 >> `RWA_DWORD_SHIFT) - 32'h1; // [RULE7] [RULE1]
            next_offset = width32 >> ofs_shift; // [RULE8]
         end
         default: begin
            next_start = sum270 >> `RWA_DWORD_SHIFT; // [RULE9]
            next_offset = height32 >> ofs_shift; // [RULE6]
         end
      endcase
   end

   // multiplier operands: upper*stride, then the span term of the mode
   always @* begin
      mul_start = (state == ST_MUL_UL) || (state == ST_MUL_SPAN);
      mul_b = stride[DIM_W-1:0];
      if (state == ST_MUL_UL || state == ST_WAIT_UL) begin
         mul_a = o_upper; // [RULE2]
      end else if (rot == `RWA_ROT_180) begin
         mul_a = p_height - 1'b1; // [RULE7]
      end else if (rot == `RWA_ROT_270) begin
         mul_a = p_width - 1'b1; // [RULE9]
      end else begin
         mul_a = {DIM_W{1'b0}};
      end
   end

   rwa_mul #(
      .W(DIM_W)
   ) u_mul (
      .clk(CLK),
      .rst_n(rst_n),
      .start(mul_start),
      .a(mul_a),
      .b(mul_b),
      .done(mul_done),
      .product(mul_prod)
   );

   rwa_sync u_ack_sync (
      .clk(CLK),
      .rst_n(rst_n),
      .din(DEV_ACK),
      .dout(ack_sync)
   );

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (go) begin
               next_state = ST_MUL_UL;
            end
         end
         ST_MUL_UL: next_state = ST_WAIT_UL;
         ST_WAIT_UL: begin
            if (mul_done) begin
               next_state = ST_MUL_SPAN;
            end
         end
         ST_MUL_SPAN: next_state = ST_WAIT_SPAN;
         ST_WAIT_SPAN: begin
            if (mul_done) begin
               next_state = ST_CALC;
            end
         end
         ST_CALC: next_state = ST_WR_REQ;
         ST_WR_REQ: begin
            if (ack_sync) begin
               next_state = ST_WR_REL;
            end
         end
         ST_WR_REL: begin
            if (!ack_sync) begin
               next_state = (wr_idx == 2'h2) ? ST_FINISH : ST_WR_REQ;
            end
         end
         ST_FINISH: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         wr_idx <= 2'h0;
         rot <= `RWA_ROT_0;
         lg <= 3'h0;
         ula_prod <= 32'h0;
         start_res <= 32'h0;
         offset_res <= 32'h0;
         done_flag <= 1'b0;
         DEV_ADDR <= 8'h00;
         DEV_WDATA <= 32'h0000_0000;
         DEV_WR <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_IDLE && go) begin
            rot <= settings[`RWA_ROT_HI:`RWA_ROT_LO]; // [RULE11]
            lg <= (pixfmt > `RWA_BPP_LOG2_MAX) ? `RWA_BPP_LOG2_MAX : pixfmt;
            wr_idx <= 2'h0;
         end
         if (state == ST_WAIT_UL && mul_done) begin
            ula_prod <= mul_prod[31:0];
         end
         if (state == ST_CALC) begin
            start_res <= next_start;
            offset_res <= next_offset;
         end
         // four-phase write: hold request until ack, then wait for ack low
         if (state == ST_CALC || (state == ST_WR_REL && !ack_sync && wr_idx != 2'h2)) begin
            DEV_WR <= 1'b1;
            case (state == ST_CALC ? 2'h0 : wr_idx + 2'h1)
               2'h0: begin
                  DEV_ADDR <= `RWA_DEV_SETTINGS;
                  DEV_WDATA <= {settings[31:18], rot, settings[15:0]}; // [RULE11]
               end
               2'h1: begin
                  DEV_ADDR <= `RWA_DEV_START;
                  DEV_WDATA <= start_res; // [RULE12] [RULE13]
               end
               default: begin
                  DEV_ADDR <= `RWA_DEV_OFFSET;
                  DEV_WDATA <= offset_res; // [RULE13]
               end
            endcase
            if (state != ST_CALC) begin
               wr_idx <= wr_idx + 2'h1;
            end
         end else if (state == ST_WR_REQ && ack_sync) begin
            DEV_WR <= 1'b0;
         end
         // set wins over clear
         if (state == ST_FINISH) begin
            done_flag <= 1'b1;
         end else if (done_clr) begin
            done_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // software bus slave
   // ----------------------------------------------------------------
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         settings <= `RWA_SETTINGS_RST;
         pixfmt <= `RWA_PIXFMT_RST;
         panel <= `RWA_PANEL_RST;
         origin <= `RWA_ORIGIN_RST;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= wb_req;
         if (wb_wr && !busy) begin
            case (WB_ADR_I)
               `RWA_OFS_SETTINGS: settings <= merge(settings, WB_DAT_I, WB_SEL_I);
               `RWA_OFS_PIXFMT: begin
                  if (WB_SEL_I[0]) begin
                     pixfmt <= WB_DAT_I[2:0];
                  end
               end
               `RWA_OFS_PANEL: panel <= merge(panel, WB_DAT_I, WB_SEL_I);
               `RWA_OFS_ORIGIN: origin <= merge(origin, WB_DAT_I, WB_SEL_I); // [RULE10]
               default: settings <= settings;
            endcase
         end
         if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
               `RWA_OFS_STATUS: WB_DAT_O <= {30'h0, done_flag, busy};
               `RWA_OFS_SETTINGS: WB_DAT_O <= settings;
               `RWA_OFS_PIXFMT: WB_DAT_O <= {29'h0, pixfmt};
               `RWA_OFS_PANEL: WB_DAT_O <= panel;
               `RWA_OFS_ORIGIN: WB_DAT_O <= origin;
               `RWA_OFS_START_RES: WB_DAT_O <= start_res;
               `RWA_OFS_OFFSET_RES: WB_DAT_O <= offset_res;
               default: WB_DAT_O <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// file: core/rwa_mul.v
// Purpose: sequential shift-add multiplier, one operand bit per clock
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses one cycle, product holds until the next start
`include "rwa_consts.vh"

module rwa_mul #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_n,
   input wire start,
   input wire [W-1:0] a,
   input wire [W-1:0] b,
   output reg done,
   output reg [2*W-1:0] product
);

   reg [W-1:0] mplr;
   reg [2*W-1:0] mcand;
   reg [W:0] count;
   reg active;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mplr <= {W{1'b0}};
         mcand <= {(2*W){1'b0}};
         count <= {(W+1){1'b0}};
         active <= 1'b0;
         done <= 1'b0;
         product <= {(2*W){1'b0}};
      end else begin
         done <= 1'b0;
         if (start && !active) begin
            mplr <= a;
            mcand <= {{W{1'b0}}, b};
            product <= {(2*W){1'b0}};
            count <= {(W+1){1'b0}};
            active <= 1'b1;
         end else if (active) begin
            if (mplr[0]) begin
               product <= product + mcand;
            end
            mplr <= mplr >> 1;
            mcand <= mcand << 1;
            count <= count + 1'b1;
            if (count == W - 1) begin
               active <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule

// file: core/rwa_sync.v
// Purpose: two-flop synchroniser for one level from outside the clock domain
// Assumes: rst_n already released synchronously
// Notes: first stage is read by the second stage only
`include "rwa_consts.vh"

module rwa_sync (
   input wire clk,
   input wire rst_n,
   input wire din,
   output reg dout
);

   reg stage1;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end

endmodule

// file: shared/rwa_consts.vh
// Purpose: constants of the rotation window address setup controller
// Assumes: byte addresses on the software bus, device registers at printed offsets
// Notes: one definition per figure, included by every design file
`ifndef RWA_CONSTS_VH
`define RWA_CONSTS_VH

// ----------------------------------------------------------------
// software-side register map (byte addresses)
// ----------------------------------------------------------------
`define RWA_OFS_CTRL 8'h00
`define RWA_OFS_STATUS 8'h04
`define RWA_OFS_SETTINGS 8'h08
`define RWA_OFS_PIXFMT 8'h0C
`define RWA_OFS_PANEL 8'h10
`define RWA_OFS_ORIGIN 8'h14
`define RWA_OFS_START_RES 8'h18
`define RWA_OFS_OFFSET_RES 8'h1C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RWA_CTRL_GO 0
`define RWA_STAT_BUSY 0
`define RWA_STAT_DONE 1
`define RWA_ROT_HI 17
`define RWA_ROT_LO 16
`define RWA_SETTINGS_RST 32'h0000_0000
`define RWA_PIXFMT_RST 3'h0
`define RWA_PANEL_RST 32'h0000_0000
`define RWA_ORIGIN_RST 32'h0000_0000

// ----------------------------------------------------------------
// rotation codes
// ----------------------------------------------------------------
`define RWA_ROT_0 2'h0
`define RWA_ROT_90 2'h1
`define RWA_ROT_180 2'h2
`define RWA_ROT_270 2'h3

// ----------------------------------------------------------------
// device registers
// ----------------------------------------------------------------
`define RWA_DEV_SETTINGS 8'h10
`define RWA_DEV_START 8'h40
`define RWA_DEV_OFFSET 8'h44

// ----------------------------------------------------------------
// arithmetic constants
// ----------------------------------------------------------------
`define RWA_BPP_LOG2_MAX 3'h4
`define RWA_DWORD_SHIFT 2
`define RWA_BYTE_SHIFT 3
`define RWA_DWORD_BITS_LOG2 3'h5

`endif

// file: test/rwa_ctrl_asserts.sv
// Purpose: port-level checks of the rotation window controller
// Assumes: one clock domain, ARST_N active low
// Notes: bound to rwa_ctrl below
module rwa_ctrl_asserts #(
   parameter DIM_W = 16
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic [7:0] DEV_ADDR,
   input wire logic [31:0] DEV_WDATA,
   input wire logic DEV_WR,
   input wire logic DEV_ACK
);
   logic wr_q;
   logic [7:0] prev_addr;
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_q <= 1'b0;
         prev_addr <= 8'h44;
      end else begin
         wr_q <= DEV_WR;
         if (DEV_WR && !wr_q) prev_addr <= DEV_ADDR;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   chk_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("request not acked");
   chk_ack_idle: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
      else $error("ack without request");
   chk_dev_order: assert property ($rose(DEV_WR) |-> DEV_ADDR == ((prev_addr == 8'h10) ?
      8'h40 : (prev_addr == 8'h40) ? 8'h44 : 8'h10)) else $error("device write order");
   chk_dev_legal: assert property (DEV_WR |-> DEV_ADDR inside {8'h10, 8'h40, 8'h44})
      else $error("device address illegal");
   chk_wr_hold: assert property (DEV_WR && !DEV_ACK |=> DEV_WR)
      else $error("request dropped before ack");
   chk_wr_stable: assert property (DEV_WR && $past(DEV_WR) |-> $stable(DEV_ADDR)
      && $stable(DEV_WDATA)) else $error("request changed while held");
   chk_wr_release: assert property ($rose(DEV_ACK) |-> ##[2:4] !DEV_WR)
      else $error("request not released");
   chk_wr_rearm: assert property ($rose(DEV_WR) |-> !DEV_ACK && !$past(DEV_ACK)
      && !$past(DEV_ACK, 2)) else $error("request before ack low");
   cover property (DEV_WR && DEV_ADDR == 8'h10 && DEV_WDATA[17:16] == 2'h3);
   cover property ($rose(DEV_WR) && DEV_ADDR == 8'h44);
   cover property (WB_ACK_O && !WB_WE_I);
endmodule
bind rwa_ctrl rwa_ctrl_asserts #(.DIM_W(DIM_W)) chk_u (.CLK(CLK), .ARST_N(ARST_N),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA), .DEV_WR(DEV_WR), .DEV_ACK(DEV_ACK));

// file: test/rwa_dev_model.sv
// Purpose: display device model taking register writes over a four-phase link
// Assumes: request held until ack seen, ack dropped once request falls
// Notes: lat sets how many cycles the model stalls before acking
module rwa_dev_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] lat,
   output logic ack,
   output logic [31:0] settings,
   output logic [31:0] start,
   output logic [31:0] offset,
   output logic order_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   logic [1:0] idx;
   wire [1:0] rot = settings[17:16];
   wire [31:0] line1_byte = (start + offset) << 2;
   wire [7:0] want = (idx == 2'h0) ? 8'h10 : (idx == 2'h1) ? 8'h40 : 8'h44;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack <= 1'b0;
         cnt <= 4'h0;
         idx <= 2'h0;
         settings <= 32'h0;
         start <= 32'h0;
         offset <= 32'h0;
         order_err <= 1'b0;
      end else if (wr && !ack) begin
         if (cnt >= lat) begin
            ack <= 1'b1;
            cnt <= 4'h0;
            // values stay until rewritten
            case (addr)
               8'h10: settings <= wdata;
               8'h40: start <= wdata;
               8'h44: offset <= wdata;
               default: order_err <= 1'b1;
            endcase
            if (addr !== want) order_err <= 1'b1;
            idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
         end else cnt <= cnt + 4'h1;
      end else if (!wr) ack <= 1'b0;
   end
endmodule

// file: test/testbench.sv
// Purpose: self-checking bench of the rotation window controller
// Assumes: classic Wishbone master, device model on the far side
// Notes: fixed cases first, then random panels from an lfsr
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [3:0] lat = 4'h0;
   logic [31:0] rnd = 32'h0000_0029;
   wire [31:0] dat_o, dev_wdata, m_set, m_start, m_ofs;
   wire [7:0] dev_addr;
   wire ack, dev_wr, dev_ack, m_err;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   rwa_ctrl #(.DIM_W(16)) dut_u (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .DEV_ADDR(dev_addr), .DEV_WDATA(dev_wdata), .DEV_WR(dev_wr),
      .DEV_ACK(dev_ack));
   rwa_dev_model dev_u (.clk(clk), .arst_n(arst_n), .wr(dev_wr), .addr(dev_addr),
      .wdata(dev_wdata), .lat(lat), .ack(dev_ack), .settings(m_set), .start(m_start),
      .offset(m_ofs), .order_err(m_err));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
   endfunction
   // start in upper half, line offset in lower half; integer division truncates
   function automatic logic [63:0] expect_regs(input logic [1:0] rot, input logic [2:0] lg,
      input logic [15:0] w, input logic [15:0] h, input logic [15:0] l, input logic [15:0] u);
      int b, s, ula, st, of, bb;
      b = 1 << ((lg > 3'h4) ? 4 : lg);
      s = (rot == 2'h3) ? h * b / 8 : w * b / 8;
      ula = u * s + l / b;
      bb = ((rot == 2'h1) ? h : w) * b / 8;
      case (rot)
         2'h0: st = ula / 4;
         2'h1: st = (ula + bb + ((4 - bb) & 3)) / 4 - 1;
         2'h2: st = (ula + s * (h - 1) + bb + ((4 - bb) & 3)) / 4 - 1;
         default: st = (ula + (w - 1) * s) / 4;
      endcase
      of = ((rot[0]) ? h : w) / (32 / b);
      return {st[31:0], of[31:0]};
   endfunction
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask
   task run(input logic [1:0] rot, input logic [2:0] lg, input logic [15:0] w,
      input logic [15:0] h, input logic [15:0] l, input logic [15:0] u, input logic poke);
      logic [31:0] q, sw;
      logic [63:0] e;
      int k;
      e = expect_regs(rot, lg, w, h, l, u);
      sw = {rnd[31:18], rot, rnd[15:0]};
      wr(8'h08, sw);
      wr(8'h0C, {29'h0, lg});
      wr(8'h10, {h, w});
      wr(8'h14, {u, l});
      wr(8'h00, 32'h1);
      if (poke) wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h04, q);
      check(q & 32'h1, 32'h1);
      q = 32'h0;
      k = 0;
      while (q[1] !== 1'b1 && k < 300) begin
         rd(8'h04, q);
         k++;
      end
      check(q, 32'h2);
      wr(8'h04, 32'h2);
      rd(8'h04, q);
      check(q, 32'h0);
      rd(8'h10, q);
      check(q, {h, w});
      rd(8'h18, q);
      check(q, e[63:32]);
      rd(8'h1C, q);
      check(q, e[31:0]);
      check(m_start, e[63:32]);
      check(m_ofs, e[31:0]);
      check(m_set, sw);
      check({31'h0, m_err}, 32'h0);
      $display("test done: rotation %0d bpp log %0d", rot, lg);
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         complete_run;
      end
   end
   initial begin
      logic [31:0] q;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(8'h08 + 8'(i * 4), q);
         check(q, 32'h0);
      end
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, q);
      check(q, 32'h0);
      for (int r = 0; r < 4; r++) begin
         lat <= 4'(r * 5);
         run(2'(r), 3'h2, 16'h0140, 16'h00F0, 16'h0, 16'h0, r[0]);
      end
      run(2'h2, 3'h7, 16'h0040, 16'h0020, 16'h0003, 16'h0001, 1'b1);
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         lat <= rnd[3:0];
         run(rnd[5:4], rnd[8:6], {6'h0, rnd[13:9], 5'h0} + 16'h0020,
            {6'h0, rnd[18:14], 5'h0} + 16'h0020, {10'h0, rnd[24:19]}, {10'h0, rnd[30:25]},
            rnd[31]);
      end
      complete_run;
   end
endmodule
